/* File: include/aiorf_params.svh */
// constants for the reference, mains and nv-byte action handler
`ifndef AIORF_PARAMS_SVH
`define AIORF_PARAMS_SVH
`define AIORF_OP_READ_REF    8'h0B
`define AIORF_OP_MAINS       8'h0C
`define AIORF_OP_FETCH_NV    8'h0D
`define AIORF_OP_STORE_NV    8'h0E
`define AIORF_REF_WORDS      12
`define AIORF_TEMP_WORDS     8
`define AIORF_REPLY_MAX      38
`define AIORF_CLK_MHZ        200
`define AIORF_PERIOD60_US    16000
`define AIORF_PERIOD50_US    20000
`define AIORF_CONV_US        2000
`define AIORF_VALID_US       32000
`define AIORF_MAINS_DEFAULT  1'b0
`define AIORF_NV_WRITE_US    5000
`endif

/* File: include/aiorf_pkg.sv */
// types for the reference, mains and nv-byte action handler
package aiorf_pkg;
  typedef enum logic [2:0] {
    AIORF_IDLE     = 3'b000,
    AIORF_GET_ARG1 = 3'b001,
    AIORF_GET_ARG2 = 3'b010,
    AIORF_NV_READ  = 3'b011,
    AIORF_NV_WAIT  = 3'b100,
    AIORF_SEND_REF = 3'b101,
    AIORF_SEND_NV  = 3'b110,
    AIORF_NV_BUSY  = 3'b111
  } aiorf_state_t;
  typedef enum logic [0:0] {
    AIORF_MAINS_60 = 1'b0,
    AIORF_MAINS_50 = 1'b1
  } aiorf_mains_t;
endpackage

/* File: verilog/aiorf_nv_mem.sv */
// byte-wide non-volatile store model with registered read data
`timescale 1ns/100ps
`default_nettype none
module aiorf_nv_mem #(
  parameter int AW = 8
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  // read port
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output var  logic [7:0]    rd_data
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

/* File: verilog/aiorf_top.sv */
// action handler for reference readback, mains declaration and nv bytes
`timescale 1ns/100ps
`default_nettype none
`include "aiorf_params.svh"
module aiorf_top #(
  parameter int NV_AW        = 8,
  parameter int PERIOD60_CYC = `AIORF_PERIOD60_US * `AIORF_CLK_MHZ,
  parameter int PERIOD50_CYC = `AIORF_PERIOD50_US * `AIORF_CLK_MHZ,
  parameter int CONV_CYC     = `AIORF_CONV_US * `AIORF_CLK_MHZ,
  parameter int VALID_CYC    = `AIORF_VALID_US * `AIORF_CLK_MHZ,
  parameter int NV_WR_CYC    = `AIORF_NV_WRITE_US * `AIORF_CLK_MHZ
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // action byte stream from the gateway
  input  wire logic        CMD_VALID,
  input  wire logic [7:0]  CMD_BYTE,
  output var  logic        CMD_READY,
  // reply byte stream
  output var  logic        RSP_VALID,
  output var  logic [7:0]  RSP_BYTE,
  input  wire logic        RSP_READY,
  // converter side: latest raw codes of the twelve internal sources
  input  wire logic [15:0] REF_CODE [0:11],
  output var  logic        CONV_START,
  output var  logic [3:0]  CONV_SRC,
  output var  logic        CONV_HIGH_GAIN,
  output var  logic        INTEG_TICK,
  // module state
  output var  logic        MAINS_50HZ,
  output var  logic        REF_VALID
);
  localparam int RLEN = 2 * (`AIORF_REF_WORDS);
  localparam int CW   = $clog2(PERIOD60_CYC + PERIOD50_CYC + VALID_CYC + CONV_CYC + NV_WR_CYC + 2);

  // counters and the reply index are sized for these ranges only
  if (NV_AW < 1 || NV_AW > 8 || PERIOD60_CYC < 1 || PERIOD50_CYC < 1 || CONV_CYC < 12 || NV_WR_CYC < 1 ||
      VALID_CYC < 1 || RLEN > `AIORF_REPLY_MAX) begin : g_bad_params
    $error("aiorf_top: unsupported parameter values");
  end

  function automatic logic is_high_gain(input logic [3:0] src);
    is_high_gain = (src == 4'h2) || (src == 4'h3);
  endfunction

  // command state
  aiorf_pkg::aiorf_state_t state, next_state;
  logic [7:0]  op, next_op;
  logic [7:0]  arg, next_arg;
  logic [4:0]  idx, next_idx;
  logic [CW-1:0] wcnt, next_wcnt;
  logic        mains, next_mains;
  logic        cmd_ready, next_cmd_ready;
  logic        rsp_valid, next_rsp_valid;
  logic [7:0]  rsp_byte, next_rsp_byte;
  logic        nv_wr, nv_rd;
  logic [7:0]  nv_q;
  logic [15:0] held [0:11];
  logic [15:0] next_held [0:11];

  // background refresh state
  logic [CW-1:0] pcnt, next_pcnt;
  logic [CW-1:0] vcnt, next_vcnt;
  logic [3:0]  src, next_src;
  logic        gain, next_gain;
  logic        conv, next_conv;
  logic        tick, next_tick;
  logic        valid, next_valid;

  aiorf_nv_mem #(.AW(NV_AW)) u_mem (
    .clk     (CLK),
    .wr_en   (nv_wr),
    .wr_addr (arg[NV_AW-1:0]),
    .wr_data (CMD_BYTE),
    .rd_en   (nv_rd),
    .rd_addr (arg[NV_AW-1:0]),
    .rd_data (nv_q)
  );

  wire logic take = CMD_VALID && cmd_ready;
  wire logic sent = rsp_valid && RSP_READY;

  always_comb begin
    next_state     = state;
    next_op        = op;
    next_arg       = arg;
    next_idx       = idx;
    next_wcnt      = wcnt;
    next_mains     = mains;
    next_cmd_ready = cmd_ready;
    next_rsp_valid = rsp_valid;
    next_rsp_byte  = rsp_byte;
    nv_wr          = 1'b0;
    nv_rd          = 1'b0;
    case (state)
      aiorf_pkg::AIORF_IDLE: begin
        if (take) begin
          next_op = CMD_BYTE;
          if (CMD_BYTE == `AIORF_OP_READ_REF) begin
            next_cmd_ready = 1'b0;
            next_idx       = 5'h00;
            next_rsp_valid = 1'b1;
            next_rsp_byte  = held[0][7:0];
            next_state     = aiorf_pkg::AIORF_SEND_REF;
          end else if (CMD_BYTE == `AIORF_OP_MAINS || CMD_BYTE == `AIORF_OP_FETCH_NV ||
                       CMD_BYTE == `AIORF_OP_STORE_NV) begin
            next_state = aiorf_pkg::AIORF_GET_ARG1;
          end
        end
      end
      aiorf_pkg::AIORF_GET_ARG1: begin
        if (take) begin
          next_arg = CMD_BYTE;
          if (op == `AIORF_OP_MAINS) begin
            next_mains = CMD_BYTE[0];
            next_state = aiorf_pkg::AIORF_IDLE;
          end else if (op == `AIORF_OP_FETCH_NV) begin
            next_cmd_ready = 1'b0;
            next_state     = aiorf_pkg::AIORF_NV_READ;
          end else begin
            next_state = aiorf_pkg::AIORF_GET_ARG2;
          end
        end
      end
      aiorf_pkg::AIORF_GET_ARG2: begin
        if (take) begin
          nv_wr          = 1'b1;
          next_cmd_ready = 1'b0;
          next_wcnt      = CW'(NV_WR_CYC - 1);
          next_state     = aiorf_pkg::AIORF_NV_BUSY;
        end
      end
      aiorf_pkg::AIORF_NV_BUSY: begin
        if (wcnt == '0) begin
          next_cmd_ready = 1'b1; // store is slow, so the link stalls here
          next_state     = aiorf_pkg::AIORF_IDLE;
        end else begin
          next_wcnt = wcnt - CW'(1);
        end
      end
      aiorf_pkg::AIORF_NV_READ: begin
        nv_rd      = 1'b1;
        next_state = aiorf_pkg::AIORF_NV_WAIT;
      end
      aiorf_pkg::AIORF_NV_WAIT: begin
        next_rsp_valid = 1'b1;
        next_rsp_byte  = nv_q;
        next_state     = aiorf_pkg::AIORF_SEND_NV;
      end
      aiorf_pkg::AIORF_SEND_NV: begin
        if (sent) begin
          next_rsp_valid = 1'b0;
          next_cmd_ready = 1'b1;
          next_state     = aiorf_pkg::AIORF_IDLE;
        end
      end
      aiorf_pkg::AIORF_SEND_REF: begin
        if (sent) begin
          if (idx == 5'(RLEN - 1)) begin
            next_rsp_valid = 1'b0;
            next_cmd_ready = 1'b1;
            next_state     = aiorf_pkg::AIORF_IDLE;
          end else begin
            next_idx      = idx + 5'h01;
            // low byte first, words in source order
            next_rsp_byte = next_idx[0] ? held[next_idx[4:1]][15:8] : held[next_idx[4:1]][7:0];
          end
        end
      end
      default: begin
        next_state = aiorf_pkg::AIORF_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state     <= aiorf_pkg::AIORF_IDLE;
      op        <= 8'h00;
      arg       <= 8'h00;
      idx       <= 5'h00;
      wcnt      <= '0;
      mains     <= `AIORF_MAINS_DEFAULT;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_byte  <= 8'h00;
    end else begin
      state     <= next_state;
      op        <= next_op;
      arg       <= next_arg;
      idx       <= next_idx;
      wcnt      <= next_wcnt;
      mains     <= next_mains;
      cmd_ready <= next_cmd_ready;
      rsp_valid <= next_rsp_valid;
      rsp_byte  <= next_rsp_byte;
    end
  end

  // background conversions; held values only change outside the AIORF_SEND_REF state
  always_comb begin
    next_pcnt  = pcnt + CW'(1);
    next_vcnt  = vcnt;
    next_src   = src;
    next_gain  = gain;
    next_conv  = 1'b0;
    next_tick  = 1'b0;
    next_valid = valid;
    for (int i = 0; i < 12; i++) begin
      next_held[i] = held[i];
    end
    // at or past the end, so a switch to the shorter period never runs the counter round
    if (pcnt >= CW'((mains ? PERIOD50_CYC : PERIOD60_CYC) - 1)) begin
      next_pcnt = '0;
      next_tick = 1'b1;
    end
    if (pcnt[CW-1:0] % CW'(CONV_CYC / 12) == '0) begin
      next_conv = 1'b1;
      next_src  = (src == 4'hB) ? 4'h0 : src + 4'h1;
      next_gain = is_high_gain(next_src);
      if (state != aiorf_pkg::AIORF_SEND_REF) begin
        next_held[src] = REF_CODE[src];
      end
    end
    if (!valid) begin
      if (vcnt == CW'(VALID_CYC - 1)) begin
        next_valid = 1'b1;
      end else begin
        next_vcnt = vcnt + CW'(1);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pcnt  <= '0;
      vcnt  <= '0;
      src   <= 4'h0;
      gain  <= 1'b0;
      conv  <= 1'b0;
      tick  <= 1'b0;
      valid <= 1'b0;
      for (int i = 0; i < 12; i++) begin
        held[i] <= 16'h0000;
      end
    end else begin
      pcnt  <= next_pcnt;
      vcnt  <= next_vcnt;
      src   <= next_src;
      gain  <= next_gain;
      conv  <= next_conv;
      tick  <= next_tick;
      valid <= next_valid;
      for (int i = 0; i < 12; i++) begin
        held[i] <= next_held[i];
      end
    end
  end

  // range selection per channel is owned by the range action elsewhere
  assign CMD_READY      = cmd_ready;
  assign RSP_VALID      = rsp_valid;
  assign RSP_BYTE       = rsp_byte;
  assign CONV_START     = conv;
  assign CONV_SRC       = src;
  assign CONV_HIGH_GAIN = gain;
  assign INTEG_TICK     = tick;
  assign MAINS_50HZ     = mains;
  assign REF_VALID      = valid;
endmodule
`default_nettype wire

/* File: verif/aiorf_top_props.sv */
// port checker for the action handler
`timescale 1ns/100ps
`default_nettype none
module aiorf_top_chk #(
  // defaults follow the shortened timing of the bench; the bind passes none
  parameter int PERIOD60_CYC = 200,
  parameter int PERIOD50_CYC = 250,
  parameter int VALID_CYC    = 100
) (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       CMD_VALID,
  input wire logic [7:0] CMD_BYTE,
  input wire logic       CMD_READY,
  input wire logic       RSP_VALID,
  input wire logic [7:0] RSP_BYTE,
  input wire logic       RSP_READY,
  input wire logic       CONV_START,
  input wire logic [3:0] CONV_SRC,
  input wire logic       CONV_HIGH_GAIN,
  input wire logic       INTEG_TICK,
  input wire logic       MAINS_50HZ,
  input wire logic       REF_VALID
);
  logic        tk;
  logic [1:0]  args;
  logic [7:0]  op;
  logic [5:0]  nrsp;
  logic [31:0] gap;
  logic [31:0] up;
  logic        seen;
  logic        m_q;
  logic        mchg;
  localparam int PMAX = (PERIOD50_CYC > PERIOD60_CYC) ? PERIOD50_CYC : PERIOD60_CYC;
  assign tk = CMD_VALID && CMD_READY;
  // argument count tells opcodes from argument bytes of equal value
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      args <= 2'h0;
      op   <= 8'h00;
      nrsp <= 6'h00;
      gap  <= 32'h0;
      up   <= 32'h0;
      seen <= 1'b0;
      m_q  <= 1'b0;
      mchg <= 1'b0;
    end else begin
      if (tk && args == 2'h0) begin
        op   <= CMD_BYTE;
        args <= (CMD_BYTE == 8'h0E) ? 2'h2 : (CMD_BYTE == 8'h0C || CMD_BYTE == 8'h0D) ? 2'h1 : 2'h0;
      end else if (tk) begin
        args <= args - 2'h1;
      end
      nrsp <= CMD_READY ? 6'h00 : nrsp + {5'h00, RSP_VALID && RSP_READY};
      gap  <= INTEG_TICK ? 32'h0 : gap + 32'h1;
      seen <= seen || INTEG_TICK;
      // a period in which the mains choice moved may be cut short
      m_q  <= MAINS_50HZ;
      mchg <= (INTEG_TICK ? 1'b0 : mchg) || (MAINS_50HZ != m_q);
      up   <= (up == 32'hFFFFFFFF) ? up : up + 32'h1;
    end
  end
  rst_state_a: assert property (@(posedge CLK)
    !RST_N |=> CMD_READY && !RSP_VALID && !MAINS_50HZ && !REF_VALID) else $error("reset state wrong");
  ref_reply_a: assert property (@(posedge CLK) disable iff (!RST_N)
    tk && args == 2'h0 && CMD_BYTE == 8'h0B |=> RSP_VALID && !CMD_READY) else $error("no reference reply");
  nv_reply_a: assert property (@(posedge CLK) disable iff (!RST_N)
    tk && args == 2'h1 && op == 8'h0D |=> !RSP_VALID [*2] ##1 RSP_VALID) else $error("nv reply late");
  mains_set_a: assert property (@(posedge CLK) disable iff (!RST_N)
    tk && args == 2'h1 && op == 8'h0C |-> ##3 MAINS_50HZ == $past(CMD_BYTE[0], 3)) else $error("mains not set");
  store_busy_a: assert property (@(posedge CLK) disable iff (!RST_N)
    tk && args == 2'h1 && op == 8'h0E |=> !CMD_READY [*8]) else $error("store not busy");
  hold_reply_a: assert property (@(posedge CLK) disable iff (!RST_N)
    RSP_VALID && !RSP_READY |=> RSP_VALID && $stable(RSP_BYTE)) else $error("reply byte dropped");
  reply_len_a: assert property (@(posedge CLK) disable iff (!RST_N)
    RSP_VALID |-> nrsp < 6'h18) else $error("reply too long");
  gain_sel_a: assert property (@(posedge CLK) disable iff (!RST_N)
    CONV_START |-> CONV_HIGH_GAIN == (CONV_SRC == 4'h2 || CONV_SRC == 4'h3)) else $error("wrong gain");
  tick_gap_a: assert property (@(posedge CLK) disable iff (!RST_N)
    INTEG_TICK && seen |-> (mchg ? gap <= PMAX - 1 : gap == (m_q ? PERIOD50_CYC : PERIOD60_CYC) - 1))
    else $error("bad period");
  valid_wait_a: assert property (@(posedge CLK) disable iff (!RST_N)
    REF_VALID |-> up >= VALID_CYC - 2) else $error("valid too early");
endmodule
bind aiorf_top aiorf_top_chk chk_u (
  .CLK(CLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID), .CMD_BYTE(CMD_BYTE), .CMD_READY(CMD_READY),
  .RSP_VALID(RSP_VALID), .RSP_BYTE(RSP_BYTE), .RSP_READY(RSP_READY), .CONV_START(CONV_START),
  .CONV_SRC(CONV_SRC), .CONV_HIGH_GAIN(CONV_HIGH_GAIN), .INTEG_TICK(INTEG_TICK),
  .MAINS_50HZ(MAINS_50HZ), .REF_VALID(REF_VALID));
`default_nettype wire

/* File: verif/aiorf_gateway.sv */
// gateway model: offers action bytes, takes reply bytes
`timescale 1ns/100ps
`default_nettype none
module aiorf_gateway #(
  parameter int VALID_CYC = 100
) (
  input  wire logic       clk,
  output var  logic       cmd_valid,
  output var  logic [7:0] cmd_byte,
  input  wire logic       cmd_ready,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_byte,
  output var  logic       rsp_ready
);
  int stall = 0;
  initial begin
    cmd_valid = 1'b0;
    cmd_byte  = 8'h00;
    rsp_ready = 1'b0;
  end
  // held values are junk until the start-up wait has run out
  task automatic settle();
    repeat (VALID_CYC + 2) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_byte  = b;
    // ready is read a step after the edge, where it stands for the next one
    while (cmd_ready !== 1'b1 && n < 200) begin
      n++;
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    // released lane shows the inverse so a stale byte never looks right
    cmd_byte  = ~b;
  endtask
  task automatic recv(output logic [7:0] b);
    int n;
    n = 0;
    repeat (stall + 1) @(posedge clk);
    #1;
    rsp_ready = 1'b1;
    while (rsp_valid !== 1'b1 && n < 200) begin
      n++;
      @(posedge clk);
      #1;
    end
    b = rsp_byte;
    @(posedge clk);
    #1;
    rsp_ready = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verif/aiorf_top_test.sv */
// testbench for the action handler
`timescale 1ns/100ps
`default_nettype none
module aiorf_top_test;
  localparam int P60 = 200;
  localparam int P50 = 250;
  localparam int CONV = 48;
  logic        clk, rst_n, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
  logic        conv_start, conv_high_gain, integ_tick, mains_50hz, ref_valid;
  logic [7:0]  cmd_byte, rsp_byte;
  logic [3:0]  conv_src;
  logic [15:0] ref_code [0:11];
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  aiorf_top #(.PERIOD60_CYC(P60), .PERIOD50_CYC(P50), .CONV_CYC(CONV), .VALID_CYC(100), .NV_WR_CYC(10)) dut_u (
    .CLK(clk), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_BYTE(cmd_byte), .CMD_READY(cmd_ready),
    .RSP_VALID(rsp_valid), .RSP_BYTE(rsp_byte), .RSP_READY(rsp_ready), .REF_CODE(ref_code),
    .CONV_START(conv_start), .CONV_SRC(conv_src), .CONV_HIGH_GAIN(conv_high_gain),
    .INTEG_TICK(integ_tick), .MAINS_50HZ(mains_50hz), .REF_VALID(ref_valid));
  aiorf_gateway gw_u (.clk(clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_ready(rsp_ready));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
  endtask
  task automatic t_ref(input int stall);
    logic [7:0] b;
    gw_u.stall = stall;
    gw_u.send(8'h0B);
    for (int k = 0; k < 24; k++) begin
      gw_u.recv(b);
      chk({8'h00, b}, {8'h00, k[0] ? ref_code[k/2][15:8] : ref_code[k/2][7:0]});
    end
    repeat (3) @(posedge clk);
    #1;
    chk({15'h0000, rsp_valid}, 16'h0000);
  endtask
  task automatic tick_gap(output int p);
    p = 0;
    while (integ_tick !== 1'b1 && p < 1000) begin
      p++;
      @(posedge clk);
      #1;
    end
    p = 1;
    @(posedge clk);
    #1;
    while (integ_tick !== 1'b1 && p < 1000) begin
      p++;
      @(posedge clk);
      #1;
    end
  endtask
  task automatic t_mains(input logic [7:0] code, input int exp_p);
    int p;
    gw_u.send(8'h0C);
    gw_u.send(code);
    repeat (4) @(posedge clk);
    #1;
    chk({15'h0000, mains_50hz}, {15'h0000, code[0]});
    tick_gap(p);
    tick_gap(p);
    chk(p[15:0], exp_p[15:0]);
  endtask
  task automatic t_nv(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] b;
    gw_u.send(8'h0E);
    gw_u.send(a);
    gw_u.send(d);
    // an unknown code offered while the store is busy must wait, then vanish
    gw_u.send(8'h0F);
    gw_u.send(8'h0D);
    gw_u.send(a);
    gw_u.recv(b);
    chk({8'h00, b}, {8'h00, d});
  endtask
  task automatic t_conv();
    int n;
    n = 0;
    repeat (10 * CONV) begin
      @(posedge clk);
      #1;
      if (conv_start === 1'b1) n++;
    end
    chk(n[15:0], 16'h0078);
  endtask
  initial begin
    rst_n = 1'b0;
    for (int i = 0; i < 12; i++) ref_code[i] = 16'hA050 + 16'(i * 16'h0111);
    do_reset();
    chk({15'h0000, mains_50hz}, 16'h0000);
    chk({15'h0000, ref_valid}, 16'h0000);
    gw_u.settle();
    chk({15'h0000, ref_valid}, 16'h0001);
    t_ref(0);
    t_ref(2);
    for (int i = 0; i < 12; i++) ref_code[i] = ref_code[i] ^ 16'hFFFF;
    repeat (2 * CONV) @(posedge clk);
    #1;
    t_ref(1);
    t_conv();
    t_mains(8'h01, P50);
    t_mains(8'h02, P60);
    t_nv(8'h00, 8'h5A);
    t_nv(8'hFF, 8'hA5);
    t_mains(8'h01, P50);
    do_reset();
    chk({15'h0000, mains_50hz}, 16'h0000);
    chk({15'h0000, ref_valid}, 16'h0000);
    close_out();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end
endmodule
`default_nettype wire
